/* core/fhr_pkg.sv */
package fhr_pkg;
    // parameter addresses as seen by the fieldbus master
    localparam logic [15:0] ADDR_FAULT_CODE_READ = 16'h3c02;
    localparam logic [15:0] ADDR_FAULT_SEVERITY = 16'h3c04;
    localparam logic [15:0] ADDR_FAULT_TIMESTAMP = 16'h3c06;
    localparam logic [15:0] ADDR_FAULT_DETAIL = 16'h3c08;

    // history geometry
    localparam int HIST_DEPTH = 10;
    localparam int PTR_W = 4;
    localparam int ENTRY_W = 80;
    // entry layout: code, severity, timestamp, detail
    localparam int CODE_MSB = 79;
    localparam int SEV_MSB = 63;
    localparam int TIME_MSB = 47;
    localparam int DET_MSB = 15;

    // value limits
    localparam logic [15:0] SEV_MAX = 16'h0004;
    localparam logic [31:0] TIME_MAX = 32'h1fffffff;

    // severity codes
    localparam logic [15:0] SEV_WARN = 16'h0000;
    localparam logic [15:0] SEV_QSTOP = 16'h0001;
    localparam logic [15:0] SEV_QSTOP_OFF = 16'h0002;
    localparam logic [15:0] SEV_FATAL_ACK = 16'h0003;

    // drive states entered by a fault reaction
    localparam logic [3:0] STATE_NONE = 4'h0;
    localparam logic [3:0] STATE_QSTOP = 4'h7;
    localparam logic [3:0] STATE_QSTOP_OFF = 4'h8;
    localparam logic [3:0] STATE_FAULT = 4'h9;

    // latched fault flag bit positions
    localparam int FLAG_GENERAL = 0;
    localparam int FLAG_LIMIT = 1;
    localparam int FLAG_RANGE = 2;
    localparam int FLAG_BUS_QSTOP = 3;
    localparam int FLAG_STO = 4;
    localparam int FLAG_RS485 = 6;
    localparam int FLAG_ETH = 8;
    localparam int FLAG_MODE = 10;

    // reset values
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;

    // readout sequencer, one-hot
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_FETCH = 2'b10
    } fhr_state_t;
endpackage : fhr_pkg

/* core/fhr_hist_mem.sv */
`timescale 1ns/100ps
module fhr_hist_mem
#(
    parameter int DEPTH = fhr_pkg::HIST_DEPTH,
    parameter int W = fhr_pkg::ENTRY_W
)
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic wr_in,
    input wire logic [W-1:0] wr_data_in,
    input wire logic clr_in,
    input wire logic rd_in,
    input wire logic [fhr_pkg::PTR_W-1:0] rd_addr_in,
    output logic [W-1:0] rd_data_out
);
    import fhr_pkg::*;

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [W-1:0] next_rd_data;

    // append at first empty slot; when full, drop oldest and shift down
    always_comb
    begin
        logic placed;
        placed = 1'b0;
        for (int i = 0; i < DEPTH; i++)
        begin
            next_mem[i] = mem[i];
        end
        if (clr_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                next_mem[i] = '0;
            end
        end
        else if (wr_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (!placed && mem[i][CODE_MSB -: 16] == 16'h0000)
                begin
                    next_mem[i] = wr_data_in;
                    placed = 1'b1;
                end
            end
            if (!placed)
            begin
                for (int i = 0; i < DEPTH - 1; i++)
                begin
                    next_mem[i] = mem[i + 1];
                end
                next_mem[DEPTH-1] = wr_data_in;
            end
        end
    end

    // out-of-range addresses read as an empty entry
    always_comb
    begin
        next_rd_data = rd_data_out;
        if (rd_in)
        begin
            next_rd_data = '0;
            if (int'(rd_addr_in) < DEPTH)
            begin
                next_rd_data = mem[rd_addr_in];
            end
        end
    end

    // storage has no reset: history must survive power-down
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem[i] <= next_mem[i];
        end
    end

    // registered read port
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rd_data_out <= '0;
        end
        else
        begin
            rd_data_out <= next_rd_data;
        end
    end
endmodule : fhr_hist_mem

/* core/fhr_top.sv */
`timescale 1ns/100ps
module fhr_top
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    // fieldbus parameter read port
    input wire logic param_rd_in,
    input wire logic [15:0] param_addr_in,
    output logic [31:0] rd_data_out,
    output logic rd_valid_out,
    output logic rd_error_out,
    // neighbouring history controls
    input wire logic history_pointer_rewind_in,
    input wire logic history_clear_in,
    // fault logging from drive logic
    input wire logic log_wr_in,
    input wire logic [15:0] log_code_in,
    input wire logic [15:0] log_severity_in,
    input wire logic [15:0] log_detail_in,
    input wire logic [4:0] log_flag_bit_in,
    input wire logic [31:0] op_hours_in,
    // category events from drive logic
    input wire logic general_warn_in,
    input wire logic travel_range_in,
    input wire logic bus_quick_stop_in,
    input wire logic rs485_fault_in,
    input wire logic eth_fault_in,
    input wire logic mode_error_in,
    input wire logic flags_clear_in,
    // pins
    input wire logic safe_torque_off_input_a_in,
    input wire logic safe_torque_off_input_b_in,
    input wire logic positive_limit_input_in,
    input wire logic negative_limit_input_in,
    // status
    output logic [31:0] latched_fault_flags_out,
    output logic [3:0] reaction_state_out,
    output logic reaction_ackable_out
);
    import fhr_pkg::*;

    // drive state entered for a given severity
    function automatic logic [3:0] sev_target(input logic [15:0] sev);
        logic [3:0] st;
        st = STATE_FAULT;
        if (sev == SEV_WARN)
        begin
            st = STATE_NONE;
        end
        else if (sev == SEV_QSTOP)
        begin
            st = STATE_QSTOP;
        end
        else if (sev == SEV_QSTOP_OFF)
        begin
            st = STATE_QSTOP_OFF;
        end
        return st;
    endfunction : sev_target

    fhr_state_t state, next_state;
    logic [PTR_W-1:0] ptr, next_ptr;
    logic fetch_end, next_fetch_end;
    logic [15:0] buf_sev, next_buf_sev;
    logic [31:0] buf_time, next_buf_time;
    logic [15:0] buf_det, next_buf_det;
    logic [31:0] next_rd_data;
    logic next_rd_valid, next_rd_error;
    logic [31:0] next_flags;
    logic [3:0] next_reaction_state;
    logic next_reaction_ackable;
    logic [3:0] pin_sync1, pin_sync2;
    logic mem_rd;
    logic [ENTRY_W-1:0] mem_rd_data;
    logic [ENTRY_W-1:0] log_entry;
    logic [15:0] log_sev_clamped;
    logic [31:0] log_time_clamped;
    logic log_accept;

    // clamp logged values into documented ranges
    always_comb
    begin
        log_sev_clamped = (log_severity_in > SEV_MAX) ? SEV_MAX : log_severity_in;
        log_time_clamped = (op_hours_in > TIME_MAX) ? TIME_MAX : op_hours_in;
        log_accept = log_wr_in && (log_code_in != 16'h0000);
        log_entry = {log_code_in, log_sev_clamped, log_time_clamped, log_detail_in};
    end

    // ten-entry non-volatile history, oldest first
    fhr_hist_mem #(
        .DEPTH(HIST_DEPTH),
        .W(ENTRY_W)
    ) u_hist (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .wr_in(log_accept),
        .wr_data_in(log_entry),
        .clr_in(history_clear_in),
        .rd_in(mem_rd),
        .rd_addr_in(ptr),
        .rd_data_out(mem_rd_data)
    );

    // readout sequencer: code read fetches entry, other fields come from buffer
    always_comb
    begin
        next_state = state;
        next_ptr = ptr;
        next_fetch_end = fetch_end;
        next_buf_sev = buf_sev;
        next_buf_time = buf_time;
        next_buf_det = buf_det;
        next_rd_data = rd_data_out;
        next_rd_valid = 1'b0;
        next_rd_error = 1'b0;
        mem_rd = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (param_rd_in)
                begin
                    if (param_addr_in == ADDR_FAULT_CODE_READ)
                    begin
                        mem_rd = 1'b1;
                        next_fetch_end = (int'(ptr) >= HIST_DEPTH);
                        if (int'(ptr) < HIST_DEPTH)
                        begin
                            next_ptr = ptr + 4'h1;
                        end
                        next_state = ST_FETCH;
                    end
                    else if (param_addr_in == ADDR_FAULT_SEVERITY)
                    begin
                        next_rd_data = {16'h0000, buf_sev};
                        next_rd_valid = 1'b1;
                    end
                    else if (param_addr_in == ADDR_FAULT_TIMESTAMP)
                    begin
                        next_rd_data = buf_time;
                        next_rd_valid = 1'b1;
                    end
                    else if (param_addr_in == ADDR_FAULT_DETAIL)
                    begin
                        next_rd_data = {16'h0000, buf_det};
                        next_rd_valid = 1'b1;
                    end
                    else
                    begin
                        next_rd_data = 32'h00000000;
                        next_rd_valid = 1'b1;
                        next_rd_error = 1'b1;
                    end
                end
            end
            ST_FETCH:
            begin
                // memory returns zeros for empty slots, so code 0 marks the end
                next_rd_valid = 1'b1;
                if (fetch_end)
                begin
                    next_rd_data = 32'h00000000;
                    next_buf_sev = 16'h0000;
                    next_buf_time = 32'h00000000;
                    next_buf_det = 16'h0000;
                end
                else
                begin
                    next_rd_data = {16'h0000, mem_rd_data[CODE_MSB -: 16]};
                    next_buf_sev = mem_rd_data[SEV_MSB -: 16];
                    next_buf_time = mem_rd_data[TIME_MSB -: 32];
                    next_buf_det = mem_rd_data[DET_MSB -: 16];
                end
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        // rewind overrides an advance in the same cycle
        if (history_pointer_rewind_in)
        begin
            next_ptr = PTR_RESET;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state <= ST_IDLE;
            ptr <= PTR_RESET;
            fetch_end <= 1'b0;
            buf_sev <= 16'h0000;
            buf_time <= 32'h00000000;
            buf_det <= 16'h0000;
            rd_data_out <= 32'h00000000;
            rd_valid_out <= 1'b0;
            rd_error_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ptr <= next_ptr;
            fetch_end <= next_fetch_end;
            buf_sev <= next_buf_sev;
            buf_time <= next_buf_time;
            buf_det <= next_buf_det;
            rd_data_out <= next_rd_data;
            rd_valid_out <= next_rd_valid;
            rd_error_out <= next_rd_error;
        end
    end

    // pins cross in through two flops; only the second stage is read
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pin_sync1 <= 4'hc; // idle levels: torque-off high, limits low
            pin_sync2 <= 4'hc; // a 1 on a limit bit here would latch a false flag
        end
        else
        begin
            pin_sync1 <= {safe_torque_off_input_a_in, safe_torque_off_input_b_in,
                          positive_limit_input_in, negative_limit_input_in};
            pin_sync2 <= pin_sync1;
        end
    end

    // sticky category flags; a set in the clear cycle still lands
    always_comb
    begin
        logic [31:0] set_bits;
        set_bits = 32'h00000000;
        if (log_accept)
        begin
            set_bits[log_flag_bit_in] = 1'b1;
        end
        set_bits[FLAG_GENERAL] = set_bits[FLAG_GENERAL] | general_warn_in;
        set_bits[FLAG_LIMIT] = set_bits[FLAG_LIMIT] | pin_sync2[1] | pin_sync2[0];
        set_bits[FLAG_RANGE] = set_bits[FLAG_RANGE] | travel_range_in;
        set_bits[FLAG_BUS_QSTOP] = set_bits[FLAG_BUS_QSTOP] | bus_quick_stop_in;
        set_bits[FLAG_STO] = set_bits[FLAG_STO] | (~pin_sync2[3] & ~pin_sync2[2]);
        set_bits[FLAG_RS485] = set_bits[FLAG_RS485] | rs485_fault_in;
        set_bits[FLAG_ETH] = set_bits[FLAG_ETH] | eth_fault_in;
        set_bits[FLAG_MODE] = set_bits[FLAG_MODE] | mode_error_in;
        next_flags = (flags_clear_in ? 32'h00000000 : latched_fault_flags_out) | set_bits;
    end

    // reaction of the latest logged fault
    always_comb
    begin
        next_reaction_state = reaction_state_out;
        next_reaction_ackable = reaction_ackable_out;
        if (log_accept)
        begin
            next_reaction_state = sev_target(log_sev_clamped);
            next_reaction_ackable = (log_sev_clamped <= SEV_FATAL_ACK);
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            latched_fault_flags_out <= FLAGS_RESET;
            reaction_state_out <= STATE_NONE;
            reaction_ackable_out <= 1'b1;
        end
        else
        begin
            latched_fault_flags_out <= next_flags;
            reaction_state_out <= next_reaction_state;
            reaction_ackable_out <= next_reaction_ackable;
        end
    end
endmodule : fhr_top

/* tb/fhr_top_sva.sv */
`timescale 1ns/100ps
module fhr_top_sva
    import fhr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic param_rd_in,
    input wire logic [15:0] param_addr_in,
    input wire logic [31:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic rd_error_out,
    input wire logic general_warn_in,
    input wire logic mode_error_in,
    input wire logic flags_clear_in,
    input wire logic [31:0] latched_fault_flags_out,
    input wire logic [3:0] reaction_state_out,
    input wire logic reaction_ackable_out
);
    logic fetch;
    logic next_fetch;
    logic taken;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // requests in the fetch cycle are dropped, so track it
    assign taken = param_rd_in && !fetch;
    always_comb next_fetch = taken && param_addr_in == ADDR_FAULT_CODE_READ;
    always_ff @(posedge mclk_in or negedge rstn_in)
        if (!rstn_in)
            fetch <= 1'b0;
        else
            fetch <= next_fetch;

    a_code_timing:
        assert property (next_fetch |=> !rd_valid_out ##1 rd_valid_out && !rd_error_out)
        else $error("code read answer late or early");
    a_field_timing:
        assert property (taken && (param_addr_in == ADDR_FAULT_SEVERITY
            || param_addr_in == ADDR_FAULT_DETAIL) |=> rd_valid_out && !rd_error_out)
        else $error("field read answer missing");
    a_sev_range:
        assert property (taken && param_addr_in == ADDR_FAULT_SEVERITY
            |=> rd_data_out <= {16'h0000, SEV_MAX})
        else $error("severity out of range");
    a_time_cap:
        assert property (taken && param_addr_in == ADDR_FAULT_TIMESTAMP
            |=> rd_valid_out && rd_data_out <= TIME_MAX)
        else $error("timestamp above cap");
    a_detail_width:
        assert property (taken && param_addr_in == ADDR_FAULT_DETAIL
            |=> rd_data_out[31:16] == 16'h0000)
        else $error("detail upper half not zero");
    a_flag_sticky:
        assert property (!flags_clear_in
            |=> ($past(latched_fault_flags_out) & ~latched_fault_flags_out) == 32'h0)
        else $error("flag fell without clear");
    a_general_flag:
        assert property (general_warn_in |=> latched_fault_flags_out[FLAG_GENERAL])
        else $error("general flag not set");
    a_mode_flag:
        assert property (mode_error_in |=> latched_fault_flags_out[FLAG_MODE])
        else $error("mode flag not set");
    a_fatal_state:
        assert property (!reaction_ackable_out |-> reaction_state_out == STATE_FAULT)
        else $error("unackable reaction not in fault state");
endmodule : fhr_top_sva

bind fhr_top fhr_top_sva u_sva (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .param_rd_in(param_rd_in), .param_addr_in(param_addr_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .rd_error_out(rd_error_out),
    .general_warn_in(general_warn_in), .mode_error_in(mode_error_in),
    .flags_clear_in(flags_clear_in), .latched_fault_flags_out(latched_fault_flags_out),
    .reaction_state_out(reaction_state_out), .reaction_ackable_out(reaction_ackable_out));

/* tb/fhr_master_model.sv */
`timescale 1ns/100ps
module fhr_master_model
(
    input wire logic mclk_in,
    output logic param_rd_out,
    output logic [15:0] param_addr_out,
    output logic history_pointer_rewind_out
);
    import fhr_pkg::*;
    initial
    begin
        param_rd_out = 1'b0;
        param_addr_out = 16'h0000;
        history_pointer_rewind_out = 1'b0;
    end
    // one-cycle strobe; released address is scrambled, not left stale
    task automatic read(input logic [15:0] addr, input int gap);
        repeat (gap + 1) @(posedge mclk_in);
        param_rd_out <= 1'b1;
        param_addr_out <= addr;
        @(posedge mclk_in);
        param_rd_out <= 1'b0;
        param_addr_out <= ~addr;
        // stay quiet in the fetch cycle, a request there would be lost
        if (addr == ADDR_FAULT_CODE_READ)
            @(posedge mclk_in);
    endtask : read
    // back to the oldest entry before a sequential readout
    task automatic rewind();
        @(posedge mclk_in);
        history_pointer_rewind_out <= 1'b1;
        @(posedge mclk_in);
        history_pointer_rewind_out <= 1'b0;
    endtask : rewind
endmodule : fhr_master_model

/* tb/fhr_top_test.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module fhr_top_test;
    import fhr_pkg::*;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic param_rd, rew, hclr = 1'b0, fclr = 1'b0, log_wr = 1'b0;
    logic [15:0] addr, lcode = 16'h0, lsev = 16'h0, ldet = 16'h0;
    logic [31:0] hours = 32'h0, rd_data, flags;
    logic [5:0] ev = 6'h0;
    logic [4:0] lbit = 5'h00;
    logic safe_torque_off_input_a = 1'b1, safe_torque_off_input_b = 1'b1, lim_p = 1'b0, lim_n = 1'b0;
    logic rd_valid, rd_err, ack;
    logic [3:0] rstate;
    logic [79:0] hist[$];
    logic [32:0] expq[$];
    logic [32:0] e_v;
    logic [3:0] rs_tab [6] = '{STATE_NONE, STATE_QSTOP, STATE_QSTOP_OFF, STATE_FAULT,
        STATE_FAULT, STATE_FAULT};
    int fbit [9] = '{0, 2, 3, 6, 8, 10, 1, 1, 4};
    int mismatches = 0, comparisons = 0, cycles = 0, seed;

    always #4 mclk_in = ~mclk_in;

    fhr_master_model u_master (.mclk_in(mclk_in), .param_rd_out(param_rd),
        .param_addr_out(addr), .history_pointer_rewind_out(rew));

    fhr_top u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .param_rd_in(param_rd),
        .param_addr_in(addr), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .rd_error_out(rd_err), .history_pointer_rewind_in(rew), .history_clear_in(hclr),
        .log_wr_in(log_wr), .log_code_in(lcode), .log_severity_in(lsev),
        .log_detail_in(ldet), .log_flag_bit_in(lbit), .op_hours_in(hours),
        .general_warn_in(ev[0]), .travel_range_in(ev[1]), .bus_quick_stop_in(ev[2]),
        .rs485_fault_in(ev[3]), .eth_fault_in(ev[4]), .mode_error_in(ev[5]),
        .flags_clear_in(fclr), .safe_torque_off_input_a_in(safe_torque_off_input_a),
        .safe_torque_off_input_b_in(safe_torque_off_input_b), .positive_limit_input_in(lim_p),
        .negative_limit_input_in(lim_n), .latched_fault_flags_out(flags),
        .reaction_state_out(rstate), .reaction_ackable_out(ack));

    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    // oldest note against each answer as it appears
    always @(posedge mclk_in)
        if (rd_valid === 1'b1)
        begin
            e_v = (expq.size() > 0) ? expq.pop_front() : {33{1'b1}};
            `CHK("read", e_v, {rd_err, rd_data})
        end

    task automatic log_fault(input logic [15:0] c, input logic [15:0] s, input logic [31:0] t);
        logic [15:0] d;
        d = 16'($urandom);
        @(posedge mclk_in);
        log_wr <= 1'b1;
        lcode <= c;
        lsev <= s;
        ldet <= d;
        lbit <= c[4:0];
        hours <= t;
        if (c != 16'h0000)
            hist.push_back({c, (s > SEV_MAX) ? SEV_MAX : s,
                (t > TIME_MAX) ? TIME_MAX : t, d});
        if (hist.size() > HIST_DEPTH)
            void'(hist.pop_front());
        @(posedge mclk_in);
        log_wr <= 1'b0;
    endtask : log_fault

    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        expq.push_back(e);
        u_master.read(a, $urandom_range(0, 2));
    endtask : rd

    // past the stored entries everything reads as zero
    task automatic read_entry(input int i);
        logic [79:0] en;
        en = (i < hist.size()) ? hist[i] : 80'h0;
        rd(ADDR_FAULT_CODE_READ, {17'h0, en[79:64]});
        rd(ADDR_FAULT_SEVERITY, {17'h0, en[63:48]});
        rd(ADDR_FAULT_TIMESTAMP, {1'b0, en[47:16]});
        rd(ADDR_FAULT_DETAIL, {17'h0, en[15:0]});
        rd(ADDR_FAULT_SEVERITY, {17'h0, en[63:48]});
    endtask : read_entry

    initial
    begin
        seed = $urandom(9);
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        hclr <= 1'b1;
        @(posedge mclk_in);
        hclr <= 1'b0;
        u_master.rewind();
        read_entry(0);
        #1;
        `CHK("flags", FLAGS_RESET, flags)
        // every severity code, the last one above range and clamped
        for (int s = 0; s < 6; s++)
        begin
            log_fault(16'(s + 1), 16'(s), TIME_MAX + 32'(s) - 32'h2);
            repeat (3) @(posedge mclk_in);
            #1;
            `CHK("state", rs_tab[s], rstate)
            `CHK("ack", s < 4, ack)
            `CHK("log flag", (32'h1 << (s + 2)) - 32'h2, flags)
        end
        // code 0 marks an empty slot, so that log changes nothing
        log_fault(16'h0000, 16'h0000, 32'h0);
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK("state", STATE_FAULT, rstate)
        `CHK("log flag", 1'b0, flags[0])
        // twelve entries in all, so the oldest two drop out
        for (int j = 0; j < 6; j++)
            log_fault(16'($urandom_range(1, 65535)), 16'($urandom_range(0, 4)), $urandom);
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK("log flag", 1'b1, flags[lbit])
        u_master.rewind();
        for (int i = 0; i < 12; i++)
            read_entry(i);
        rd(16'h3c0a, {1'b1, 32'h0});
        // each category source alone after a clear
        for (int k = 0; k < 9; k++)
        begin
            @(posedge mclk_in);
            fclr <= 1'b1;
            @(posedge mclk_in);
            fclr <= 1'b0;
            lim_p <= (k == 6);
            lim_n <= (k == 7);
            safe_torque_off_input_a <= (k != 8);
            safe_torque_off_input_b <= (k != 8);
            if (k < 6)
                ev[k] <= 1'b1;
            repeat (3) @(posedge mclk_in);
            ev <= 6'h0;
            lim_p <= 1'b0;
            lim_n <= 1'b0;
            safe_torque_off_input_a <= 1'b1;
            safe_torque_off_input_b <= 1'b1;
            repeat (4) @(posedge mclk_in);
            #1;
            `CHK("flags", 32'h1 << fbit[k], flags)
        end
        `CHK("pending", 0, expq.size())
        complete_run();
    end
endmodule : fhr_top_test
